// ===== verilog/rmpp_defs.svh
// constants of the radio modem packet path
// How it works
// - flow mode: data goes to terminal only while RTS is active, else held
// - reception-control mode: inactive RTS aborts reception at once, back to wait
// - terminal data starts a transmission; preamble goes first while bytes buffer
// - transmission ends after a serial gap and once the buffer is empty
// - transmit buffer is 1 kB; overfilling flushes it and restarts transmission
// - serial data during radio reception is buffered, sent once channel frees
// - start delay of 1 to 65000 ms buffers data; 0 ms disables it
// - test mode sends one test packet each second, needing no terminal input
// - test packet is 52 characters short or 988 characters long
// - test mode stays on until configuration turns it off
// - repeater accepts packets of up to 1 kB for retransmission
// - repeater passes data to serial, stores it, resends after reception
// - repeater still transmits terminal data in the ordinary way
// - two send and two accept addresses; each direction enabled on its own
// - serial-originated packets use the primary send address unless sharing a transmission with a secondary-hit repeat
// - repeated packets use the send address matching the accept address hit
// - receive addressing compares first two characters with both addresses
// - address is 16 bits, high byte then low byte, any value allowed
// - send addressing off sends unchanged; on prepends the send address
// - option keeps received address characters on the serial output
// - matching packets lose their address; non-matching ones are dropped
// - receive addressing off forwards every character unchanged
`ifndef RMPP_DEFS_SVH
`define RMPP_DEFS_SVH
// register byte offsets
`define RMPP_OFS_CTRL    8'h00
`define RMPP_OFS_DELAY   8'h04
`define RMPP_OFS_GAP     8'h08
`define RMPP_OFS_SENDADR 8'h0c
`define RMPP_OFS_ACCADR  8'h10
`define RMPP_OFS_STATUS  8'h14
// control fields
`define RMPP_RTS_IGNORE  2'h0
`define RMPP_RTS_FLOW    2'h1
`define RMPP_RTS_RXCTL   2'h2
`define RMPP_CTL_TEST    2
`define RMPP_CTL_LONG    3
`define RMPP_CTL_REP     4
`define RMPP_CTL_SENDA   5
`define RMPP_CTL_ACCA    6
`define RMPP_CTL_A2SER   7
`define RMPP_STAT_OVF    31
// reset values
`define RMPP_RST_CHARCYC 20'h065ba
`define RMPP_RST_GAPCH   8'h03
// buffer shape and test packet lengths
`define RMPP_BUF_DEPTH   1024
`define RMPP_PTR_W       10
`define RMPP_TEST_SHORT  10'd52
`define RMPP_TEST_LONG   10'd988
// timing
`define RMPP_CLK_NS      20
`define RMPP_MS_NS       1000000
`define RMPP_TEST_MS     1000
`define RMPP_MS_CYC      (`RMPP_MS_NS / `RMPP_CLK_NS)
`define RMPP_TEST_CYC    (`RMPP_TEST_MS * `RMPP_MS_CYC)
`endif

// ===== verilog/rmpp_pkg.sv
// types of the radio modem packet path
package rmpp_pkg;
    typedef enum logic [4:0] {
        TX_IDLE  = 5'b00001,
        TX_DELAY = 5'b00010,
        TX_PRE   = 5'b00100,
        TX_ADDR  = 5'b01000,
        TX_SEND  = 5'b10000
    } rmpp_tx_t;
    typedef enum logic [3:0] {
        RX_WAIT = 4'b0001,
        RX_ADDR = 4'b0010,
        RX_PASS = 4'b0100,
        RX_DROP = 4'b1000
    } rmpp_rx_t;
    typedef struct packed {
        logic            rtsMeta;
        logic            rtsSync;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
        logic [7:0]      ctrl;
        logic [15:0]     delayMs;
        logic [19:0]     charCyc;
        logic [7:0]      gapChars;
        logic [15:0]     sendPri;
        logic [15:0]     sendSec;
        logic [15:0]     accPri;
        logic [15:0]     accSec;
        logic            ovf;
        rmpp_tx_t        txSt;
        rmpp_rx_t        rxSt;
        logic [15:0]     msCnt;
        logic [15:0]     dlyCnt;
        logic [27:0]     idleCnt;
        logic            addrIdx;
        logic            useSec;
        logic            pendSec;
        logic            txOn;
        logic            txValid;
        logic [7:0]      txData;
        logic            outValid;
        logic [7:0]      outData;
        logic            rxEn;
        logic [7:0]      addrHi;
        logic            matchSec;
        logic            rxPendV;
        logic [7:0]      rxPendD;
        logic            repV;
        logic [7:0]      repD;
        logic [25:0]     secCnt;
        logic [9:0]      testLeft;
        logic [7:0]      testSeq;
    } rmpp_state_t;
endpackage : rmpp_pkg

// ===== verilog/rmpp_buf.sv
// byte buffer of 1 kB held in flip-flops, with flush
`timescale 1ns/1ps
`include "rmpp_defs.svh"
module rmpp_buf
    import rmpp_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rstN,
    input  wire logic                  flush,
    input  wire logic                  wrEn,
    input  wire logic [7:0]            wrData,
    input  wire logic                  rdEn,
    output      logic [7:0]            rdData,
    output      logic [`RMPP_PTR_W:0]  count
);
    typedef struct packed {
        logic [`RMPP_BUF_DEPTH-1:0][7:0] mem;
        logic [`RMPP_PTR_W-1:0]          wp;
        logic [`RMPP_PTR_W-1:0]          rp;
        logic [`RMPP_PTR_W:0]            cnt;
    } rmpp_bufst_t;
    rmpp_bufst_t s, next_s;
    logic        doWr, doRd;

    // ring pointers; writes to a full ring are dropped
    always_comb begin
        next_s = s;
        doWr = wrEn && (s.cnt != (`RMPP_PTR_W+1)'(`RMPP_BUF_DEPTH));
        doRd = rdEn && (s.cnt != '0);
        if (doWr) begin
            next_s.mem[s.wp] = wrData;
            next_s.wp = s.wp + 1'b1;
        end
        if (doRd) begin
            next_s.rp = s.rp + 1'b1;
        end
        next_s.cnt = s.cnt + {{`RMPP_PTR_W{1'b0}}, doWr}
                   - {{`RMPP_PTR_W{1'b0}}, doRd};
        if (flush) begin
            next_s.wp = '0;
            next_s.rp = '0;
            next_s.cnt = '0;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdData = s.mem[s.rp];
    assign count = s.cnt;
endmodule : rmpp_buf

// ===== verilog/rmpp_top.sv
// packet path between serial terminal and half-duplex radio
`timescale 1ns/1ps
`include "rmpp_defs.svh"
module rmpp_top
    import rmpp_pkg::*;
#(
    parameter int MS_CYC   = `RMPP_MS_CYC,
    parameter int TEST_CYC = `RMPP_TEST_CYC
)(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic        pready,
    output      logic [31:0] prdata,
    output      logic        pslverr,
    input  wire logic        termRts,
    input  wire logic        serInValid,
    input  wire logic [7:0]  serInData,
    output      logic        serOutValid,
    output      logic [7:0]  serOutData,
    input  wire logic        serOutReady,
    input  wire logic        radioRxActive,
    input  wire logic        radioRxValid,
    input  wire logic [7:0]  radioRxData,
    output      logic        radioRxEnable,
    output      logic        radioTxOn,
    input  wire logic        radioPreambleDone,
    output      logic        radioTxValid,
    output      logic [7:0]  radioTxData,
    input  wire logic        radioTxReady
);
    rmpp_state_t          s, next_s;
    logic [1:0]           rstSync;
    logic                 rstN;
    logic                 txW, txR, txFlush, rxW, rxR;
    logic [7:0]           txWD, rxWD, txRd, rxRd;
    logic [`RMPP_PTR_W:0] txCnt, rxCnt;
    logic                 rts, gapSeen, txFull, txFree, outFree;
    logic                 rxOk, pass, ovfEvt, testTick;
    logic [1:0]           mode;
    logic [15:0]          rxAddr, sendAddr;

    // total idle cycles that close a packet
    function automatic logic [27:0] gap_limit(input logic [19:0] cyc,
                                              input logic [7:0]  chars);
        gap_limit = 28'(cyc) * 28'(chars);
    endfunction : gap_limit

    // test packet length for the selected variant
    function automatic logic [9:0] test_len(input logic long);
        test_len = long ? `RMPP_TEST_LONG : `RMPP_TEST_SHORT;
    endfunction : test_len

    // ************************************************************
    // reset release
    // ************************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    // ************************************************************
    // buffers
    // ************************************************************
    rmpp_buf u_txbuf (
        .core_clk (core_clk),
        .rstN     (rstN),
        .flush    (txFlush),
        .wrEn     (txW),
        .wrData   (txWD),
        .rdEn     (txR),
        .rdData   (txRd),
        .count    (txCnt)
    );
    rmpp_buf u_rxbuf (
        .core_clk (core_clk),
        .rstN     (rstN),
        .flush    (1'b0),
        .wrEn     (rxW),
        .wrData   (rxWD),
        .rdEn     (rxR),
        .rdData   (rxRd),
        .count    (rxCnt)
    );

    // shared decodes
    assign rts = s.rtsSync;
    assign mode = s.ctrl[1:0];
    assign gapSeen = s.idleCnt >= gap_limit(s.charCyc, s.gapChars);
    assign txFull = txCnt == (`RMPP_PTR_W+1)'(`RMPP_BUF_DEPTH);
    assign txFree = !s.txValid || radioTxReady;
    assign outFree = !s.outValid || serOutReady;
    assign rxOk = !(mode == `RMPP_RTS_RXCTL && !rts);
    assign rxAddr = {s.addrHi, radioRxData};
    assign sendAddr = s.useSec ? s.sendSec : s.sendPri;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_s = s;
        txW = 1'b0;
        txWD = 8'h00;
        txR = 1'b0;
        txFlush = 1'b0;
        rxW = 1'b0;
        rxWD = 8'h00;
        rxR = 1'b0;
        pass = 1'b0;
        ovfEvt = 1'b0;
        testTick = 1'b0;
        // terminal handshake pin synchroniser
        next_s.rtsMeta = termRts;
        next_s.rtsSync = s.rtsMeta;

        // apb slave: answer one cycle into the access phase
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        if (psel && penable && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h0;
            case (paddr)
                `RMPP_OFS_CTRL: begin
                    if (pwrite) next_s.ctrl = pwdata[7:0];
                    next_s.prdata = {24'h0, s.ctrl};
                end
                `RMPP_OFS_DELAY: begin
                    if (pwrite) next_s.delayMs = pwdata[15:0];
                    next_s.prdata = {16'h0, s.delayMs};
                end
                `RMPP_OFS_GAP: begin
                    if (pwrite) begin
                        next_s.charCyc = pwdata[19:0];
                        next_s.gapChars = pwdata[27:20];
                    end
                    next_s.prdata = {4'h0, s.gapChars, s.charCyc};
                end
                `RMPP_OFS_SENDADR: begin
                    if (pwrite) begin
                        next_s.sendPri = pwdata[15:0];
                        next_s.sendSec = pwdata[31:16];
                    end
                    next_s.prdata = {s.sendSec, s.sendPri};
                end
                `RMPP_OFS_ACCADR: begin
                    if (pwrite) begin
                        next_s.accPri = pwdata[15:0];
                        next_s.accSec = pwdata[31:16];
                    end
                    next_s.prdata = {s.accSec, s.accPri};
                end
                `RMPP_OFS_STATUS: begin
                    if (pwrite && pwdata[`RMPP_STAT_OVF]) next_s.ovf = 1'b0;
                    next_s.prdata = {s.ovf, 4'h0, rxCnt, 5'h0, txCnt};
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end

        // idle character-time counter on the serial input
        if (serInValid) begin
            next_s.idleCnt = 28'h0;
        end else if (!gapSeen) begin
            next_s.idleCnt = s.idleCnt + 28'h1;
        end

        // radio receive path with address filter
        next_s.rxEn = rxOk;
        if (!rxOk) begin
            next_s.rxSt = RX_WAIT;
            next_s.rxPendV = 1'b0;
        end else begin
            if (s.rxPendV) begin
                rxW = 1'b1;
                rxWD = s.rxPendD;
                next_s.rxPendV = 1'b0;
            end
            if (radioRxValid) begin
                case (s.rxSt)
                    RX_WAIT: begin
                        next_s.matchSec = 1'b0;
                        if (s.ctrl[`RMPP_CTL_ACCA]) begin
                            next_s.addrHi = radioRxData;
                            next_s.rxSt = RX_ADDR;
                        end else begin
                            pass = 1'b1;
                            next_s.rxSt = RX_PASS;
                        end
                    end
                    RX_ADDR: begin
                        if (rxAddr == s.accPri || rxAddr == s.accSec) begin
                            next_s.rxSt = RX_PASS;
                            next_s.matchSec = rxAddr != s.accPri;
                            if (s.ctrl[`RMPP_CTL_A2SER]) begin
                                rxW = 1'b1;
                                rxWD = s.addrHi;
                                next_s.rxPendV = 1'b1;
                                next_s.rxPendD = radioRxData;
                            end
                        end else begin
                            next_s.rxSt = RX_DROP;
                        end
                    end
                    RX_PASS: begin
                        pass = 1'b1;
                    end
                    RX_DROP: begin
                        pass = 1'b0;
                    end
                    default: begin
                        next_s.rxSt = RX_WAIT;
                    end
                endcase
            end
            if (pass) begin
                rxW = 1'b1;
                rxWD = radioRxData;
                if (s.ctrl[`RMPP_CTL_REP]) begin
                    next_s.repV = 1'b1;
                    next_s.repD = radioRxData;
                end
            end
            if (!radioRxActive && s.rxSt != RX_WAIT) begin
                next_s.rxSt = RX_WAIT;
                if (s.rxSt == RX_PASS && s.ctrl[`RMPP_CTL_REP]) begin
                    next_s.pendSec = s.matchSec;
                end
            end
        end

        // rx buffer drain towards the terminal
        if (outFree) begin
            next_s.outValid = 1'b0;
            if ((mode != `RMPP_RTS_FLOW || rts) && rxCnt != '0) begin
                rxR = 1'b1;
                next_s.outValid = 1'b1;
                next_s.outData = rxRd;
            end
        end

        // test packet timer, runs while test mode is configured on
        if (!s.ctrl[`RMPP_CTL_TEST]) begin
            next_s.secCnt = 26'h0;
        end else if (s.secCnt == 26'(TEST_CYC - 1)) begin
            next_s.secCnt = 26'h0;
            if (s.testLeft == 10'h0) begin
                testTick = 1'b1;
                next_s.testLeft = test_len(s.ctrl[`RMPP_CTL_LONG]);
                next_s.testSeq = s.testSeq + 8'h1;
            end
        end else begin
            next_s.secCnt = s.secCnt + 26'h1;
        end

        // tx buffer writers: terminal, then repeat byte, then test
        if (serInValid) begin
            if (txFull) begin
                ovfEvt = 1'b1;
            end else begin
                txW = 1'b1;
                txWD = serInData;
            end
        end else if (s.repV) begin
            txW = 1'b1;
            txWD = s.repD;
            next_s.repV = 1'b0;
        end else if (s.testLeft != 10'h0 && !txFull) begin
            txW = 1'b1;
            txWD = (s.testLeft == test_len(s.ctrl[`RMPP_CTL_LONG]))
                 ? s.testSeq : 8'h41 + {3'h0, s.testLeft[4:0]};
            next_s.testLeft = s.testLeft - 10'h1;
        end

        // transmit sequencer
        if (txFree) begin
            next_s.txValid = 1'b0;
        end
        case (s.txSt)
            TX_IDLE: begin
                next_s.txOn = 1'b0;
                next_s.txValid = 1'b0;
                // wait for the rx tail, so a repeat has its address choice
                if (txCnt != '0 && !radioRxActive
                        && s.rxSt == RX_WAIT) begin
                    next_s.useSec = s.pendSec;
                    next_s.pendSec = 1'b0;
                    next_s.msCnt = 16'h0;
                    next_s.dlyCnt = 16'h0;
                    if (s.delayMs != 16'h0) begin
                        next_s.txSt = TX_DELAY;
                    end else begin
                        next_s.txSt = TX_PRE;
                        next_s.txOn = 1'b1;
                    end
                end
            end
            TX_DELAY: begin
                next_s.msCnt = s.msCnt + 16'h1;
                if (s.msCnt == 16'(MS_CYC - 1)) begin
                    next_s.msCnt = 16'h0;
                    next_s.dlyCnt = s.dlyCnt + 16'h1;
                    if (s.dlyCnt == s.delayMs - 16'h1) begin
                        next_s.txSt = TX_PRE;
                        next_s.txOn = 1'b1;
                    end
                end
            end
            TX_PRE: begin
                next_s.addrIdx = 1'b0;
                if (radioPreambleDone) begin
                    next_s.txSt = s.ctrl[`RMPP_CTL_SENDA] ? TX_ADDR : TX_SEND;
                end
            end
            TX_ADDR: begin
                if (txFree) begin
                    next_s.txValid = 1'b1;
                    next_s.txData = s.addrIdx ? sendAddr[7:0]
                                              : sendAddr[15:8];
                    next_s.addrIdx = 1'b1;
                    if (s.addrIdx) next_s.txSt = TX_SEND;
                end
            end
            TX_SEND: begin
                if (txFree) begin
                    if (txCnt != '0) begin
                        txR = 1'b1;
                        next_s.txValid = 1'b1;
                        next_s.txData = txRd;
                    end else if (gapSeen) begin
                        next_s.txSt = TX_IDLE;
                        next_s.txOn = 1'b0;
                    end
                end
            end
            default: begin
                next_s.txSt = TX_IDLE;
            end
        endcase

        // overflow: flush and start the transmission over
        if (ovfEvt) begin
            txFlush = 1'b1;
            txR = 1'b0;
            next_s.txSt = TX_IDLE;
            next_s.txOn = 1'b0;
            next_s.txValid = 1'b0;
            next_s.ovf = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            s <= '{charCyc: `RMPP_RST_CHARCYC, gapChars: `RMPP_RST_GAPCH,
                   txSt: TX_IDLE, rxSt: RX_WAIT, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign pready = s.pready;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign serOutValid = s.outValid;
    assign serOutData = s.outData;
    assign radioRxEnable = s.rxEn;
    assign radioTxOn = s.txOn;
    assign radioTxValid = s.txValid;
    assign radioTxData = s.txData;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstN);

    sequence sFlowHeld;
        mode == `RMPP_RTS_FLOW && !rts && !s.outValid;
    endsequence
    sequence sEndReady;
        s.txSt == TX_SEND && txCnt == '0 && gapSeen && txFree && !ovfEvt;
    endsequence

    flow_hold_a: assert property (sFlowHeld |=> !s.outValid)
        else $error("data sent to terminal while RTS inactive");
    rx_abort_a: assert property ((mode == `RMPP_RTS_RXCTL && !rts)
        |=> s.rxSt == RX_WAIT && !s.rxEn)
        else $error("reception not aborted on inactive RTS");
    preamble_first_a: assert property (s.txSt == TX_PRE
        |-> s.txOn && !s.txValid)
        else $error("data before preamble done");
    tx_end_a: assert property ($fell(s.txOn) && !$past(ovfEvt)
        |-> $past(gapSeen) && $past(txCnt) == '0)
        else $error("transmission ended early");
    tx_end_go_a: assert property (sEndReady
        |=> s.txSt == TX_IDLE && !s.txOn)
        else $error("transmission not closed");
    overflow_a: assert property (ovfEvt
        |=> txCnt == '0 && s.txSt == TX_IDLE && s.ovf)
        else $error("overflow not flushed");
    rx_busy_a: assert property ((s.txSt == TX_IDLE && radioRxActive)
        |=> s.txSt == TX_IDLE)
        else $error("transmission started during reception");
    delay_a: assert property ((s.txSt == TX_IDLE
        ##1 s.txSt == TX_DELAY) |-> s.delayMs != 16'h0)
        else $error("delay entered with zero setting");
    test_len_a: assert property (testTick |=> s.testLeft ==
        ($past(s.ctrl[`RMPP_CTL_LONG]) ? `RMPP_TEST_LONG
                                        : `RMPP_TEST_SHORT))
        else $error("wrong test packet length");
    addr_send_a: assert property ((s.txSt == TX_PRE
        ##1 s.txSt == TX_ADDR) |-> s.ctrl[`RMPP_CTL_SENDA])
        else $error("address sent with send addressing off");
endmodule : rmpp_top

// ===== tb/rmpp_term_model.sv
// terminal model: serial bytes in and out, rts line
`timescale 1ns/1ps
module rmpp_term_model (
    input  wire logic       core_clk,
    output      logic       termRts,
    output      logic       serInValid,
    output      logic [7:0] serInData,
    input  wire logic       serOutValid,
    input  wire logic [7:0] serOutData,
    output      logic       serOutReady
);
    logic       slow = 1'b0;
    logic [7:0] gotQ[$];
    initial begin
        termRts = 1'b1;
        serInValid = 1'b0;
        serInData = 8'h00;
        serOutReady = 1'b0;
    end
    // take output bytes; a slow terminal accepts every other cycle
    always @(posedge core_clk) begin
        if (serOutValid && serOutReady) gotQ.push_back(serOutData);
        serOutReady <= slow ? ~serOutReady : 1'b1;
    end
    // bytes back to back; data is scrambled once released
    task send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            serInValid <= 1'b1;
            serInData  <= q[i];
            @(posedge core_clk);
        end
        serInValid <= 1'b0;
        serInData  <= ~q[q.size()-1];
    endtask : send
endmodule : rmpp_term_model

// ===== tb/radio_modem_packet_path_tb.sv
// self-checking bench of the radio modem packet path
`timescale 1ns/1ps
`include "rmpp_defs.svh"
module radio_modem_packet_path_tb;
    import rmpp_pkg::*;
    logic        core_clk = 1'b0, arst_n = 1'b0, pready, pslverr, err;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, serInData, serOutData, radioTxData;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        termRts, serInValid, serOutValid, serOutReady;
    logic        radioRxActive = 1'b0, radioRxValid = 1'b0, radioRxEnable;
    logic [7:0]  radioRxData = 8'h00, txQ[$];
    logic        radioTxReady = 1'b1, radioPreambleDone = 1'b0;
    logic        radioTxOn, radioTxValid;
    int          num_errors = 0, cmp_count = 0;
    always #10 core_clk = ~core_clk;
    // modulator: preamble done a cycle after keying, bytes collected
    always @(posedge core_clk) begin
        radioPreambleDone <= radioTxOn;
        if (radioTxValid && radioTxReady) txQ.push_back(radioTxData);
    end
    rmpp_top #(.MS_CYC(10), .TEST_CYC(200)) u_dut (.*);
    rmpp_term_model u_term (.*);
    // ********************
    // bus, radio and check tasks
    // ********************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task radioPkt(input logic [7:0] q[$]);
        radioRxActive <= 1'b1;
        foreach (q[i]) begin
            @(posedge core_clk);
            radioRxValid <= 1'b1;
            radioRxData  <= q[i];
            @(posedge core_clk);
            radioRxValid <= 1'b0;
            radioRxData  <= ~q[i];
        end
        @(posedge core_clk);
        radioRxActive <= 1'b0;
        @(posedge core_clk);
    endtask : radioPkt
    task waittx(input int n);
        for (int i = 0; i < 400 && (txQ.size() < n || radioTxOn); i++)
            @(posedge core_clk);
    endtask : waittx
    task waitq(input int n);
        for (int i = 0; i < 300 && u_term.gotQ.size() < n; i++)
            @(posedge core_clk);
    endtask : waitq
    task finish_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    initial begin
        #1000000;
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, `RMPP_OFS_GAP, 32'h0);
        chk(rd, 32'h0030_65ba);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, `RMPP_OFS_GAP, 32'h0010_0004);
        // flow mode holds bytes while rts is low
        apb(1'b1, `RMPP_OFS_CTRL, 32'h1);
        u_term.termRts <= 1'b0;
        radioPkt({8'h56, 8'h78});
        repeat (40) @(posedge core_clk);
        chk(u_term.gotQ.size(), 0);
        u_term.termRts <= 1'b1;
        waitq(2);
        chk({u_term.gotQ[0], u_term.gotQ[1]}, 16'h5678);
        // accept addressing: miss dropped, secondary hit stripped
        u_term.gotQ.delete();
        u_term.slow = 1'b1;
        apb(1'b1, `RMPP_OFS_ACCADR, 32'h5678_1234);
        apb(1'b1, `RMPP_OFS_CTRL, 32'h40);
        radioPkt({8'h11, 8'h22, 8'h33});
        radioPkt({8'h56, 8'h78, 8'h9a});
        waitq(2);
        chk(u_term.gotQ.size(), 1);
        chk(u_term.gotQ[0], 8'h9a);
        // send addressing: primary address leads the packet
        apb(1'b1, `RMPP_OFS_SENDADR, 32'habcd_1234);
        apb(1'b1, `RMPP_OFS_CTRL, 32'h20);
        u_term.send({8'ha1, 8'ha2});
        waittx(4);
        chk({txQ[0], txQ[1], txQ[2], txQ[3]}, 32'h1234_a1a2);
        chk(radioTxOn, 1'b0);
        // repeater: secondary accept hit goes out on secondary send address
        txQ.delete();
        u_term.gotQ.delete();
        apb(1'b1, `RMPP_OFS_CTRL, 32'h70);
        radioPkt({8'h56, 8'h78, 8'hc3});
        waitq(1);
        chk(u_term.gotQ[0], 8'hc3);
        waittx(3);
        chk({txQ[0], txQ[1], txQ[2]}, 24'habcdc3);
        // test mode: one short packet led by its sequence number
        txQ.delete();
        apb(1'b1, `RMPP_OFS_CTRL, 32'h04);
        waittx(52);
        chk(txQ.size(), 52);
        chk(txQ[0], 8'h01);
        finish_test();
    end
endmodule : radio_modem_packet_path_tb
